// *** rtl/msmm_core.sv ***
// Purpose: Mode latch, address decode and startup protection.
// Assumes: One bus cycle per clk_i; bus_valid_i marks a CPU access.
// Notes: Mode pins are sampled every cycle reset is held.
`timescale 1ns/1ps
module msmm_core (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    input wire logic fetch_first_i,
    input wire logic eclk_i,
    input wire logic bus_valid_i,
    input wire logic bus_write_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    output logic mode_pin_a_o,
    output logic mode_pin_a_oe_o,
    output logic eclk_o,
    output logic [7:0] reg_rdata_o,
    output logic sel_reg_o,
    output logic sel_ram_o,
    output logic sel_rom_o,
    output logic sel_boot_o,
    output logic ext_cycle_o,
    output logic vis_drive_o,
    output logic [1:0] mode_o,
    output logic rom_at_top_o,
    output logic nocop_o,
    output logic [7:0] sys_choice_o
);
    logic in_reset_reg;
    logic boot_reg;
    logic special_reg;
    logic mda_reg;
    logic irv_reg;
    logic [3:0] psel_reg;
    logic rom_top_reg;
    logic [6:0] cyc_reg;
    logic [7:0] rdata_reg;
    logic [7:0] mapping_q;
    logic [7:0] startup_q;
    logic [7:0] choice_q;
    logic map_done;
    logic start_done_unused;
    logic choice_done_unused;
    logic window;
    logic reg_hit;
    logic ram_hit;
    logic rom_hit;
    logic boot_hit;
    logic wr_prio;
    logic wr_map;
    logic wr_start;
    logic wr_choice;
    logic rd_any;
    logic expanded;
    logic [3:0] rom_page;
    logic [7:0] prio_view;
    logic [7:0] rdata_next;
    logic mda_next;
    logic special_next;
    logic boot_next;
    msmm_pkg::msmm_mode_t mode_now;

    // Address decode of the internal resources.
    assign reg_hit = bus_addr_i[15:12] == mapping_q[3:0]
        && bus_addr_i[11:6] == 6'h00;
    assign ram_hit = bus_addr_i[15:12] == mapping_q[7:4]
        && bus_addr_i[11:8] == 4'h0
        && bus_addr_i[7:0] >= msmm_pkg::RAM_LO
        && !reg_hit;
    assign rom_page = (mode_now == msmm_pkg::MSMM_EXPAND && !rom_top_reg)
        ? msmm_pkg::ROM_EXP_PAGE : msmm_pkg::ROM_TOP_PAGE;
    assign boot_hit = boot_reg && special_reg
        && bus_addr_i >= msmm_pkg::BOOT_LO
        && bus_addr_i <= msmm_pkg::BOOT_HI;
    assign rom_hit = startup_q[msmm_pkg::BIT_ROMP]
        && bus_addr_i[15:12] == rom_page
        && !reg_hit && !ram_hit && !boot_hit;

    // Current mode and expanded flag.
    assign mode_now = msmm_pkg::msmm_mode_t'({special_reg, mda_reg});
    assign expanded = mda_reg;

    // Bus selects; unmapped accesses go out only in expanded modes.
    assign sel_reg_o = bus_valid_i & ~in_reset_reg & reg_hit;
    assign sel_ram_o = bus_valid_i & ~in_reset_reg & ram_hit;
    assign sel_boot_o = bus_valid_i & ~in_reset_reg & boot_hit & ~reg_hit;
    assign sel_rom_o = bus_valid_i & ~in_reset_reg & rom_hit;
    assign ext_cycle_o = bus_valid_i & ~in_reset_reg & expanded
        & ~(reg_hit | ram_hit | rom_hit | boot_hit);

    // Internal read visibility in expanded and test modes.
    assign rd_any = bus_valid_i & ~bus_write_i & ~in_reset_reg;
    assign vis_drive_o = rd_any & expanded & irv_reg
        & (reg_hit | ram_hit | rom_hit | boot_hit);

    // E clock gated only in single-chip modes.
    assign eclk_o = (!expanded && irv_reg) ? 1'b0 : eclk_i;

    // Fetch marker: open drain, low on first E cycle, never in reset.
    assign mode_pin_a_o = 1'b0;
    assign mode_pin_a_oe_o = ~sys_rst_i & ~in_reset_reg
        & fetch_first_i;

    // Register write strobes.
    assign wr_prio = sel_reg_o & bus_write_i
        & bus_addr_i[5:0] == msmm_pkg::OFS_PRIO_MODE;
    assign wr_map = sel_reg_o & bus_write_i
        & bus_addr_i[5:0] == msmm_pkg::OFS_MAPPING;
    assign wr_start = sel_reg_o & bus_write_i
        & bus_addr_i[5:0] == msmm_pkg::OFS_STARTUP;
    assign wr_choice = sel_reg_o & bus_write_i
        & bus_addr_i[5:0] == msmm_pkg::OFS_SYSCHOICE;
    assign window = cyc_reg < msmm_pkg::PROT_LIMIT;

    // Priority and mode write: special only clears, mode-A only special.
    assign special_next = (wr_prio && special_reg)
        ? bus_wdata_i[msmm_pkg::BIT_SPEC] & special_reg
        : special_reg;
    assign mda_next = (wr_prio && special_reg)
        ? bus_wdata_i[msmm_pkg::BIT_MDA] : mda_reg;
    assign boot_next = (wr_prio && special_reg)
        ? bus_wdata_i[msmm_pkg::BIT_BOOT] : boot_reg;
    assign prio_view = {boot_reg & special_reg, special_reg, mda_reg,
        irv_reg, psel_reg};

    // Read data mux.
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (bus_addr_i[5:0])
            msmm_pkg::OFS_PRIO_MODE: rdata_next = prio_view;
            msmm_pkg::OFS_MAPPING: rdata_next = mapping_q;
            msmm_pkg::OFS_STARTUP: rdata_next = startup_q;
            msmm_pkg::OFS_SYSCHOICE: rdata_next = choice_q;
            default: rdata_next = 8'h00;
        endcase
    end

    // Mode latch: held while reset, pins sampled; afterwards changed only by priority writes.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            in_reset_reg <= 1'b1;
            boot_reg <= ~mode_pin_b_i & ~mode_pin_a_i;
            special_reg <= ~mode_pin_b_i;
            mda_reg <= mode_pin_a_i;
            irv_reg <= ~mode_pin_b_i & mode_pin_a_i;
            psel_reg <= msmm_pkg::PSEL_RST;
            rom_top_reg <= ~mode_pin_a_i;
        end
        else
        begin
            in_reset_reg <= 1'b0;
            boot_reg <= boot_next;
            special_reg <= special_next;
            mda_reg <= mda_next;
            if (wr_prio)
            begin
                irv_reg <= bus_wdata_i[msmm_pkg::BIT_IRV];
                psel_reg <= bus_wdata_i[3:0];
            end
        end
    end

    // Bus cycle counter for the protection window.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cyc_reg <= 7'h00;
        else if (bus_valid_i && window)
            cyc_reg <= cyc_reg + 7'h01;
    end

    // Registered read data.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rdata_reg <= 8'h00;
        else if (rd_any && reg_hit)
            rdata_reg <= rdata_next;
    end

    // Mapping register: every bit protected.
    msmm_prot_reg #(
        .RST(msmm_pkg::MAPPING_RST),
        .MASK(8'hff),
        .PROT(8'hff)
    ) u_map (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_map),
        .wdata_i(bus_wdata_i),
        .special_i(special_reg),
        .window_i(window),
        .q_o(mapping_q),
        .done_o(map_done)
    );

    // Startup latches: rom_present forced on at reset.
    msmm_prot_reg #(
        .RST(msmm_pkg::STARTUP_RST),
        .MASK(msmm_pkg::STARTUP_MASK),
        .PROT(msmm_pkg::STARTUP_MASK)
    ) u_start (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_start),
        .wdata_i(bus_wdata_i),
        .special_i(special_reg),
        .window_i(window),
        .q_o(startup_q),
        .done_o(start_done_unused)
    );

    // System choice bits, partly protected.
    msmm_prot_reg #(
        .RST(msmm_pkg::SYSCHOICE_RST),
        .MASK(msmm_pkg::SYSCHOICE_MASK),
        .PROT(msmm_pkg::SYSCHOICE_PROT)
    ) u_choice (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(wr_choice),
        .wdata_i(bus_wdata_i),
        .special_i(special_reg),
        .window_i(window),
        .q_o(choice_q),
        .done_o(choice_done_unused)
    );

    assign reg_rdata_o = rdata_reg;
    assign mode_o = mode_now;
    assign rom_at_top_o = rom_page == msmm_pkg::ROM_TOP_PAGE;
    assign nocop_o = startup_q[msmm_pkg::BIT_NOCHK];
    assign sys_choice_o = choice_q;

    // Checks on the mode latch and map.
    special_clear_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) && !$past(special_reg) |-> !special_reg)
        else $error("special bit set by software");
    mode_frozen_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) && !$past(special_reg) |-> $stable(mda_reg))
        else $error("mode-A changed outside special mode");
    boot_gate_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        sel_boot_o |-> special_reg && bus_addr_i >= msmm_pkg::BOOT_LO)
        else $error("boot ROM selected out of mode");
    rom_off_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !startup_q[msmm_pkg::BIT_ROMP] |-> !sel_rom_o)
        else $error("ROM selected while removed");
    prio_win_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        sel_reg_o |-> !sel_rom_o && !sel_ram_o)
        else $error("register block lost priority");
    eclk_gate_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !mda_reg && irv_reg |-> !eclk_o)
        else $error("E clock not held low");
    ext_only_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ext_cycle_o |-> mda_reg && !sel_reg_o && !sel_ram_o)
        else $error("external cycle in wrong case");
    map_once_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        map_done && !special_reg |=> $stable(mapping_q))
        else $error("mapping changed after first write");
    map_reset_a: assert property (
        @(posedge clk_i)
        sys_rst_i |=> mapping_q == msmm_pkg::MAPPING_RST
            && startup_q[msmm_pkg::BIT_ROMP])
        else $error("map reset value wrong");
    marker_a: assert property (
        @(posedge clk_i)
        sys_rst_i |-> !mode_pin_a_oe_o)
        else $error("marker driven in reset");
    cover_boot_c: cover property (@(posedge clk_i) sel_boot_o);
    cover_ext_c: cover property (@(posedge clk_i) ext_cycle_o);
    cover_leave_c: cover property (@(posedge clk_i)
        $past(special_reg) && !special_reg && !sys_rst_i);
    cover_map_c: cover property (@(posedge clk_i) wr_map && window);
endmodule // msmm_core

// *** shared/msmm_pkg.sv ***
// Purpose: Constants for the mode select and memory map block.
// Assumes: 8-bit CPU bus, 16-bit addresses, one register per byte.
// Notes: Offsets are relative to the base of the 64-byte register block.
package msmm_pkg;
    // Register offsets inside the register block.
    localparam logic [5:0] OFS_SYSCHOICE = 6'h39;
    localparam logic [5:0] OFS_PRIO_MODE = 6'h3c;
    localparam logic [5:0] OFS_MAPPING = 6'h3d;
    localparam logic [5:0] OFS_STARTUP = 6'h3f;
    // Field positions in priority_and_mode.
    localparam int BIT_BOOT = 7;
    localparam int BIT_SPEC = 6;
    localparam int BIT_MDA = 5;
    localparam int BIT_IRV = 4;
    // Field positions in startup_setup_latches.
    localparam int BIT_NOCHK = 2;
    localparam int BIT_ROMP = 1;
    // Reset values.
    localparam logic [3:0] PSEL_RST = 4'h5;
    // Register block and RAM both start in page 0 after reset.
    localparam logic [7:0] MAPPING_RST = 8'h00;
    localparam logic [7:0] STARTUP_RST = 8'h02;
    localparam logic [7:0] SYSCHOICE_RST = 8'h10;
    // Writable masks; the protected bits of system_choice_bits.
    localparam logic [7:0] SYSCHOICE_MASK = 8'h3b;
    localparam logic [7:0] SYSCHOICE_PROT = 8'h33;
    localparam logic [7:0] STARTUP_MASK = 8'h06;
    // Window of protected writes in bus cycles.
    localparam int PROT_CYCLES = 64;
    localparam logic [6:0] PROT_LIMIT = 7'(PROT_CYCLES);
    // Address ranges.
    localparam logic [15:0] BOOT_LO = 16'hbf40;
    localparam logic [15:0] BOOT_HI = 16'hbfff;
    localparam logic [3:0] ROM_TOP_PAGE = 4'hf;
    localparam logic [3:0] ROM_EXP_PAGE = 4'h7;
    localparam logic [7:0] RAM_LO = 8'h40;
    // Operating modes as {special, mode_a}.
    typedef enum logic [1:0] {
        MSMM_SINGLE = 2'b00,
        MSMM_EXPAND = 2'b01,
        MSMM_BOOT = 2'b10,
        MSMM_TEST = 2'b11
    } msmm_mode_t;
endpackage

// *** rtl/msmm_prot_reg.sv ***
// Purpose: One byte register guarded by a once-only write window.
// Assumes: Caller supplies the open window and the special flag.
// Notes: Free bits are always writable; protected bits follow the window.
`timescale 1ns/1ps
module msmm_prot_reg #(
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] PROT = 8'hff
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic special_i,
    input wire logic window_i,
    output logic [7:0] q_o,
    output logic done_o
);
    logic [7:0] q_reg;
    logic [7:0] q_next;
    logic done_reg;
    logic prot_ok;
    logic [7:0] wmask;

    // Protected bits open in special modes, or once inside the window.
    assign prot_ok = special_i | (window_i & ~done_reg);
    assign wmask = MASK & (prot_ok ? 8'hff : ~PROT);
    assign q_next = (q_reg & ~wmask) | (wdata_i & wmask);

    // Value register and the once-per-reset flag.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            q_reg <= RST;
            done_reg <= 1'b0;
        end
        else if (wr_i)
        begin
            q_reg <= q_next;
            done_reg <= done_reg | ~special_i;
        end
    end

    assign q_o = q_reg;
    assign done_o = done_reg;
endmodule // msmm_prot_reg

// *** tb/msmm_pins_model.sv ***
// Purpose: Strap pins and the pull-up on pin A, as the mode block sees them.
// Assumes: The bench picks the strap levels as it raises reset.
// Notes: After reset, pin B wanders so a late sample would show up.
`timescale 1ns/1ps
module msmm_pins_model (
    input wire logic sys_rst_i,
    input wire logic pick_a_i,
    input wire logic pick_b_i,
    input wire logic drive_a_i,
    input wire logic drive_a_oe_i,
    output logic mode_pin_a_o,
    output logic mode_pin_b_o
);
    // Pin A is strapped in reset, then floats high unless the device sinks it.
    assign mode_pin_a_o = sys_rst_i ? pick_a_i
        : (drive_a_oe_i ? drive_a_i : 1'b1);
    // Pin B flips after reset, so the mode must not follow it.
    assign mode_pin_b_o = sys_rst_i ? pick_b_i : ~pick_b_i;
endmodule // msmm_pins_model

// *** tb/mode_select_and_memory_map_test.sv ***
// Purpose: Self-checking bench for the mode select and memory map block.
// Assumes: One access per task call, two clocks each.
// Notes: Every task starts and ends just after a rising edge.
`timescale 1ns/1ps
`define chk(nm, exp, got) begin comparisons++; if ((got) !== (exp)) \
    begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module mode_select_and_memory_map_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pick_a = 1'b0;
    logic pick_b = 1'b1;
    logic fetch_first_i = 1'b0;
    logic eclk_i = 1'b0;
    logic bus_valid_i = 1'b0;
    logic bus_write_i = 1'b0;
    logic [15:0] bus_addr_i = 16'h0000;
    logic [7:0] bus_wdata_i = 8'h00;
    logic pin_a, pin_b, drv_a, oe_a, eclk_o, s_reg, s_ram, s_rom, s_boot;
    logic sel_reg_o, sel_ram_o, sel_rom_o, sel_boot_o, ext_cycle_o;
    logic vis_drive_o, s_ext, s_vis, rom_top, nocop;
    logic [7:0] choice;
    logic [1:0] mode_o;
    logic [7:0] reg_rdata_o, rq, e;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;

    msmm_pins_model i_msmm_pins_model (.sys_rst_i(sys_rst_i),
        .pick_a_i(pick_a), .pick_b_i(pick_b), .drive_a_i(drv_a),
        .drive_a_oe_i(oe_a), .mode_pin_a_o(pin_a), .mode_pin_b_o(pin_b));
    msmm_core i_msmm_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .mode_pin_a_i(pin_a), .mode_pin_b_i(pin_b),
        .fetch_first_i(fetch_first_i), .eclk_i(eclk_i),
        .bus_valid_i(bus_valid_i), .bus_write_i(bus_write_i),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
        .mode_pin_a_o(drv_a), .mode_pin_a_oe_o(oe_a), .eclk_o(eclk_o),
        .reg_rdata_o(reg_rdata_o), .sel_reg_o(sel_reg_o),
        .sel_ram_o(sel_ram_o), .sel_rom_o(sel_rom_o),
        .sel_boot_o(sel_boot_o), .ext_cycle_o(ext_cycle_o),
        .vis_drive_o(vis_drive_o), .mode_o(mode_o), .rom_at_top_o(rom_top),
        .nocop_o(nocop), .sys_choice_o(choice));

    // Bus clock and a free-running E clock input.
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) eclk_i <= ~eclk_i;

    // Cuts a hung run short.
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Resets with the given straps; pin A must stay released meanwhile.
    task automatic rst(input logic b, input logic a);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        pick_b <= b;
        pick_a <= a;
        fetch_first_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        `chk("marker in reset", 1'b0, oe_a)
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        fetch_first_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // One access: selects caught mid-cycle, read data the cycle after.
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [7:0] d);
        bus_valid_i <= 1'b1;
        bus_write_i <= w;
        bus_addr_i <= a;
        bus_wdata_i <= d;
        @(negedge clk_i);
        {s_reg, s_ram, s_rom, s_boot} = {sel_reg_o, sel_ram_o, sel_rom_o,
            sel_boot_o};
        {s_ext, s_vis} = {ext_cycle_o, vis_drive_o};
        @(posedge clk_i);
        bus_valid_i <= 1'b0;
        @(negedge clk_i);
        rq = reg_rdata_o;
        @(posedge clk_i);
    endtask

    // All four straps: latched bits, ROM and boot ROM placement, marker.
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            rst(~m[1], m[0]);
            `chk("mode", 2'(m), mode_o)
            e = {m == 2, m[1], m[0], m == 3, 4'h5};
            acc(1'b0, 16'h003c, 8'h00);
            `chk("prio reset", e, rq)
            acc(1'b0, 16'hf100, 8'h00);
            `chk("rom top", m != 1, s_rom)
            `chk("rom page", m != 1, rom_top)
            acc(1'b0, 16'h7100, 8'h00);
            `chk("rom low", m == 1, s_rom)
            acc(1'b0, 16'hbf40, 8'h00);
            `chk("boot rom", m == 2, s_boot)
            acc(1'b0, 16'hbf3f, 8'h00);
            `chk("boot edge", 1'b0, s_boot)
            fetch_first_i <= 1'b1;
            @(negedge clk_i);
            `chk("eclk runs", eclk_i, eclk_o)
            `chk("marker pin", 1'b0, pin_a)
            @(posedge clk_i);
            fetch_first_i <= 1'b0;
        end
    endtask

    // Single-chip map, one relocation, then a second write refused.
    task automatic t_map();
        rst(1'b1, 1'b0);
        acc(1'b0, 16'h0050, 8'h00);
        `chk("ram home", 1'b1, s_ram)
        acc(1'b0, 16'h0010, 8'h00);
        `chk("regs home", 1'b1, s_reg)
        acc(1'b0, 16'h003f, 8'h00);
        `chk("startup reset", 8'h02, rq)
        `chk("choice reset", 8'h10, choice)
        acc(1'b1, 16'h0039, 8'hff);
        `chk("choice first", 8'h3b, choice)
        acc(1'b1, 16'h0039, 8'h00);
        `chk("choice locked", 8'h33, choice)
        acc(1'b1, 16'h003f, 8'h06);
        acc(1'b1, 16'h003f, 8'h00);
        acc(1'b0, 16'h003f, 8'h00);
        `chk("startup once", 8'h06, rq)
        `chk("nocop set", 1'b1, nocop)
        acc(1'b0, 16'hf100, 8'h00);
        `chk("rom kept", 1'b1, s_rom)
        acc(1'b0, 16'h8000, 8'h00);
        `chk("no ext single", 1'b0, s_ext)
        acc(1'b1, 16'h003d, 8'h12);
        acc(1'b0, 16'h1040, 8'h00);
        `chk("ram moved", 1'b1, s_ram)
        acc(1'b0, 16'h2010, 8'h00);
        `chk("regs moved", 1'b1, s_reg)
        acc(1'b1, 16'h203d, 8'h34);
        acc(1'b0, 16'h203d, 8'h00);
        `chk("second write", 8'h12, rq)
    endtask

    // A protected write in the 65th bus cycle is refused.
    task automatic t_window();
        rst(1'b1, 1'b0);
        repeat (64) acc(1'b0, 16'h8000, 8'h00);
        acc(1'b1, 16'h003d, 8'h12);
        acc(1'b0, 16'h1040, 8'h00);
        `chk("late write", 1'b0, s_ram)
        acc(1'b0, 16'h0040, 8'h00);
        `chk("ram stays", 1'b1, s_ram)
    endtask

    // Visibility bit: E off in single-chip, read visibility when expanded.
    task automatic t_vis();
        rst(1'b1, 1'b0);
        acc(1'b1, 16'h003c, 8'h15);
        @(negedge clk_i);
        `chk("e held low", 1'b0, eclk_o)
        @(posedge clk_i);
        acc(1'b0, 16'h003c, 8'h00);
        `chk("no vis single", 1'b0, s_vis)
        rst(1'b1, 1'b1);
        acc(1'b1, 16'h003c, 8'h35);
        acc(1'b0, 16'h003c, 8'h00);
        `chk("read visible", 1'b1, s_vis)
        @(negedge clk_i);
        `chk("e kept", eclk_i, eclk_o)
        @(posedge clk_i);
        acc(1'b0, 16'h8000, 8'h00);
        `chk("ext expanded", 1'b1, s_ext)
    endtask

    // Test mode: overlap priority, ROM removal, mode bit writes.
    task automatic t_special();
        rst(1'b0, 1'b1);
        acc(1'b1, 16'h003d, 8'hff);
        acc(1'b0, 16'hf000, 8'h00);
        `chk("regs over rom", 2'b10, {s_reg, s_rom})
        acc(1'b0, 16'hf040, 8'h00);
        `chk("ram over rom", 2'b10, {s_ram, s_rom})
        acc(1'b0, 16'hf100, 8'h00);
        `chk("rom present", 1'b1, s_rom)
        acc(1'b1, 16'hf03f, 8'h00);
        acc(1'b0, 16'hf100, 8'h00);
        `chk("rom removed", 2'b01, {s_rom, s_ext})
        acc(1'b1, 16'hf03c, 8'hd5);
        `chk("mode to boot", 2'b10, mode_o)
        acc(1'b0, 16'hbf40, 8'h00);
        `chk("boot enabled", 1'b1, s_boot)
        acc(1'b0, 16'hf03c, 8'h00);
        `chk("prio special", 8'hd5, rq)
        acc(1'b1, 16'hf03c, 8'h95);
        acc(1'b0, 16'hf03c, 8'h00);
        `chk("special cleared", 8'h15, rq)
        `chk("mode single", 2'b00, mode_o)
        acc(1'b1, 16'hf03c, 8'h75);
        acc(1'b0, 16'hf03c, 8'h00);
        `chk("no set back", 8'h15, rq)
    endtask

    // Bootstrap reset, mode-A set, special cleared: expanded, ROM on top.
    task automatic t_rom_top();
        rst(1'b0, 1'b0);
        acc(1'b1, 16'h003c, 8'h65);
        acc(1'b1, 16'h003c, 8'h25);
        `chk("expanded", 2'b01, mode_o)
        acc(1'b0, 16'hf100, 8'h00);
        `chk("rom kept top", 2'b11, {s_rom, rom_top})
        acc(1'b0, 16'h7100, 8'h00);
        `chk("no rom low", 2'b01, {s_rom, s_ext})
    endtask

    // Main sequence.
    initial
    begin
        t_modes();
        t_map();
        t_window();
        t_vis();
        t_special();
        t_rom_top();
        summarize();
    end
endmodule // mode_select_and_memory_map_test
